/* byte_lane_steering.v */
// Byte-lane steering and bus-cycle sequencer for a 16-bit external data bus
// Notes on behaviour
// - An odd-address byte moves on the upper lanes with the upper enable low and address bit 0 high.
// - A byte arriving alone on the upper lanes (odd byte, odd word first half) is moved to the low half of the internal path.
// - An even-address word uses both banks in one cycle with bit 0 low and upper enable low.
// - An odd-address word first moves its low byte on the upper lanes, upper enable low, bit 0 high.
// - Its second cycle uses the incremented address, lower lanes, bit 0 low, upper enable high.
// - The split of an odd word happens by itself with nothing asked of the program.
// - Interrupt, nonmaskable interrupt and test inputs are recognised at a clock edge after sync.
`include "lane_defs.vh"
module byte_lane_steering (
	input wire clk_i, // 50 MHz clock
	input wire sys_rst_i, // Async reset, active high
	input wire req_i, // Start an access (pulse)
	input wire req_word_i, // 1 word, 0 byte
	input wire req_write_i, // 1 write, 0 read
	input wire [`ADDR_W-1:0] req_addr_i, // Byte address
	input wire [15:0] req_wdata_i, // Write data, byte in [7:0]
	output reg busy_o, // Access in progress
	output reg done_o, // Access finished (pulse)
	output reg [15:0] rdata_o, // Read data, byte in [7:0]
	output reg [`ADDR_W-1:0] bus_addr_o, // Full byte address on bus
	output reg upper_bank_enable_n_o, // Upper bank enable, active low
	output reg bus_cycle_o, // Bus cycle active (T1..T4)
	output reg bus_write_o, // Write strobe level
	output reg [15:0] bus_dout_o, // Data lanes out
	output reg bus_doe_o, // Data lanes output enable
	input wire [15:0] bus_din_i, // Data lanes in
	input wire ready_i, // Ready from bus, async
	input wire maskable_interrupt_request_i, // Maskable interrupt request, async
	input wire nmi_i, // Nonmaskable interrupt, async
	input wire test_n_i, // Test input, async, active low
	output reg maskable_interrupt_request_o, // Recognised interrupt request
	output reg nmi_o, // Recognised nonmaskable interrupt
	output reg test_n_o // Recognised test level
);
	// Bus sequencer state and captured request
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg second_q; // In second half of odd word
	reg word_q;
	reg write_q;
	reg [`ADDR_W-1:0] base_q;
	reg [15:0] wdata_q;
	// Synchroniser stages and filtered ready
	reg [2:0] rdy_s;
	reg [2:0] maskable_interrupt_request_s;
	reg [2:0] nmi_s;
	reg [2:0] test_s;
	reg rdy_q;
	// Lane choice for the first bus cycle of a new request
	reg ube_first_d;
	reg [15:0] dout_first_d;
	wire odd = bus_addr_o[0];
	wire [`ADDR_W-1:0] next_addr = base_q + {{(`ADDR_W-1){1'b0}}, 1'b1};
	wire take = (state_q == `ST_IDLE) && req_i;
	wire capture = (state_q == `ST_T3) && rdy_q;
	wire split_pending = word_q && odd && !second_q;

	// Three-stage sync; a change counts once stages two and three agree.
	// Costs about four clocks of latency, so ready must settle early.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdy_s <= 3'h0;
			maskable_interrupt_request_s <= 3'h0;
			nmi_s <= 3'h0;
			test_s <= 3'h7;
		end else begin
			rdy_s <= {rdy_s[1:0], ready_i};
			maskable_interrupt_request_s <= {maskable_interrupt_request_s[1:0], maskable_interrupt_request_i};
			nmi_s <= {nmi_s[1:0], nmi_i};
			test_s <= {test_s[1:0], test_n_i};
		end
	end

	// Filtered levels; a disagreement keeps the old value
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdy_q <= 1'b0;
			maskable_interrupt_request_o <= 1'b0;
			nmi_o <= 1'b0;
			test_n_o <= 1'b1;
		end else begin
			if (rdy_s[1] == rdy_s[2]) begin
				rdy_q <= rdy_s[2];
			end
			if (maskable_interrupt_request_s[1] == maskable_interrupt_request_s[2]) begin
				maskable_interrupt_request_o <= maskable_interrupt_request_s[2];
			end
			if (nmi_s[1] == nmi_s[2]) begin
				nmi_o <= nmi_s[2];
			end
			if (test_s[1] == test_s[2]) begin
				test_n_o <= test_s[2];
			end
		end
	end

	// Odd byte, odd word first half and even word need the upper bank
	always @* begin
		ube_first_d = ~(req_addr_i[0] | req_word_i);
		if (req_addr_i[0]) begin
			dout_first_d = {req_wdata_i[7:0], 8'h00};
		end else if (req_word_i) begin
			dout_first_d = req_wdata_i;
		end else begin
			dout_first_d = {8'h00, req_wdata_i[7:0]};
		end
	end

	// Next state; ready is looked at only in the third state and its waits
	always @* begin
		state_d = state_q;
		case (state_q)
			`ST_IDLE: begin
				if (req_i) begin
					state_d = `ST_T1;
				end
			end
			`ST_T1: begin
				state_d = `ST_T2;
			end
			`ST_T2: begin
				state_d = `ST_T3;
			end
			`ST_T3: begin
				if (rdy_q) begin
					state_d = `ST_T4;
				end
			end
			`ST_T4: begin
				if (split_pending) begin
					state_d = `ST_T1;
				end else begin
					state_d = `ST_IDLE;
				end
			end
			default: begin
				state_d = `ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= `ST_IDLE;
			second_q <= 1'b0;
			word_q <= 1'b0;
			write_q <= 1'b0;
			base_q <= {`ADDR_W{1'b0}};
			wdata_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (take) begin
				word_q <= req_word_i;
				write_q <= req_write_i;
				base_q <= req_addr_i;
				wdata_q <= req_wdata_i;
				second_q <= 1'b0;
			end else if (state_q == `ST_T4 && split_pending) begin
				second_q <= 1'b1;
			end
		end
	end

	// Bus pins hold for the whole cycle, both halves of a split word too
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			bus_addr_o <= {`ADDR_W{1'b0}};
			upper_bank_enable_n_o <= `RST_UBE_N;
			bus_cycle_o <= 1'b0;
			bus_write_o <= 1'b0;
			bus_dout_o <= 16'h0000;
			bus_doe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (take) begin
				busy_o <= 1'b1;
				bus_addr_o <= req_addr_i;
				upper_bank_enable_n_o <= ube_first_d;
				bus_cycle_o <= 1'b1;
				bus_write_o <= req_write_i;
				bus_doe_o <= req_write_i;
				bus_dout_o <= dout_first_d;
			end else if (state_q == `ST_T4) begin
				if (split_pending) begin
					bus_addr_o <= next_addr;
					upper_bank_enable_n_o <= 1'b1;
					bus_dout_o <= {8'h00, wdata_q[15:8]};
				end else begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					bus_cycle_o <= 1'b0;
					bus_write_o <= 1'b0;
					bus_doe_o <= 1'b0;
					upper_bank_enable_n_o <= `RST_UBE_N;
				end
			end
		end
	end

	// Read capture; an odd byte is moved down to the low half
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= 16'h0000;
		end else if (capture && !write_q) begin
			if (second_q) begin
				rdata_o[15:8] <= bus_din_i[7:0];
			end else if (odd) begin
				rdata_o <= {8'h00, bus_din_i[15:8]};
			end else if (word_q) begin
				rdata_o <= bus_din_i;
			end else begin
				rdata_o <= {8'h00, bus_din_i[7:0]};
			end
		end
	end
endmodule // byte_lane_steering

/* lane_defs.vh */
// Constants for the byte-lane steering block
`ifndef LANE_DEFS_VH
`define LANE_DEFS_VH
`define ADDR_W 20
`define ST_IDLE 3'h0
`define ST_T1 3'h1
`define ST_T2 3'h2
`define ST_T3 3'h3
`define ST_T4 3'h4
`define RST_UBE_N 1'h1
`endif

/* byte_lane_steering_chk.sv */
// Port assertions for byte-lane steering
`include "lane_defs.vh"
module byte_lane_steering_chk (
	input wire clk_i, // clock
	input wire sys_rst_i, // reset
	input wire req_i, // request
	input wire req_word_i, // word
	input wire req_write_i, // write
	input wire [`ADDR_W-1:0] req_addr_i, // address
	input wire [15:0] req_wdata_i, // wdata
	input wire busy_o, // busy
	input wire done_o, // done
	input wire [`ADDR_W-1:0] bus_addr_o, // bus address
	input wire upper_bank_enable_n_o, // upper enable
	input wire [15:0] bus_dout_o // lanes out
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire tk = req_i && !busy_o;
	wire b = tk && !req_word_i;
	wire wd = tk && req_word_i;
	wire odd = req_addr_i[0];
	wire ube = upper_bank_enable_n_o;
	wire a0 = bus_addr_o[0];
	a_odd_byte: assert property (b && odd |=> !ube && a0) else $error("odd byte lanes");
	a_even_byte: assert property (b && !odd |=> ube && !a0) else $error("even byte lanes");
	a_even_word: assert property (wd && !odd |=> !ube && !a0) else $error("even word lanes");
	a_odd_first: assert property (wd && odd |=> (!ube && a0)[*3]) else $error("odd first");
	a_word_addr: assert property (wd |=> bus_addr_o == $past(req_addr_i)) else $error("addr");
	a_second_half:
		assert property (busy_o && $past(busy_o) && $changed(bus_addr_o) |-> ube &&
			bus_addr_o == $past(bus_addr_o) + 20'h1) else $error("second half");
	a_odd_write:
		assert property (b && req_write_i && odd |=> bus_dout_o[15:8] == $past(req_wdata_i[7:0]))
		else $error("write lane");
	a_split_time:
		assert property (wd && odd |=> !done_o[*7] ##[1:80] done_o) else $error("split time");
	cover property (wd && odd);
	cover property (b && req_write_i);
	cover property (busy_o && $changed(bus_addr_o));
endmodule // byte_lane_steering_chk
bind byte_lane_steering byte_lane_steering_chk byte_lane_steering_chk_inst (.*);

/* bus_mem_model.sv */
// Two-bank memory model on the 16-bit data lanes
module bus_mem_model (
	input wire clk_i, // clock
	input wire cyc_i, // bus cycle
	input wire [19:0] addr_i, // address
	input wire ube_n_i, // upper enable
	input wire slow_i, // add waits
	output wire [15:0] din_o, // lanes
	output wire rdy_o // ready
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [15:0] junk_q = 16'ha5a5;
	reg [3:0] n_q = 4'h0;
	always @(posedge clk_i) begin
		junk_q <= ~junk_q;
		n_q <= cyc_i ? n_q + 4'h1 : 4'h0;
	end
	// Deselected banks float: a pattern toggling between a5 and 5a each clock
	assign din_o[15:8] = (cyc_i && !ube_n_i) ? {addr_i[7:1], 1'b1} ^ 8'h3c : junk_q[15:8];
	assign din_o[7:0] = (cyc_i && !addr_i[0]) ? {addr_i[7:1], 1'b0} ^ 8'h3c : junk_q[7:0];
	assign rdy_o = !slow_i || n_q > 4'h5;
endmodule // bus_mem_model

/* test_byte_lane_steering.sv */
// Self-checking bench for byte-lane steering
module test_byte_lane_steering;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk_i = 0, sys_rst_i = 1, req_i = 0, req_word_i = 0, req_write_i = 0, slow = 0;
	reg maskable_interrupt_request_i = 0, nmi_i = 0, test_n_i = 1;
	reg [19:0] req_addr_i = 0;
	reg [15:0] req_wdata_i = 0;
	wire busy_o, done_o, bus_cycle_o, upper_bank_enable_n_o, bus_write_o, bus_doe_o, ready_i;
	wire maskable_interrupt_request_o, nmi_o, test_n_o;
	wire [15:0] rdata_o, bus_dout_o, bus_din_i;
	wire [19:0] bus_addr_o;
	integer seed = 62527, err_total = 0, total_checks = 0, cyc = 0, i, n;
	reg [35:0] q[$];
	byte_lane_steering byte_lane_steering_inst (.*);
	bus_mem_model bus_mem_model_inst (.clk_i(clk_i), .cyc_i(bus_cycle_o), .addr_i(bus_addr_o),
		.ube_n_i(upper_bank_enable_n_o), .slow_i(slow), .din_o(bus_din_i), .rdy_o(ready_i));
	function [7:0] f(input [19:0] a);
		f = a[7:0] ^ 8'h3c;
	endfunction
	task chk(input [15:0] s, input [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop;
		end
		if (done_o === 1'b1 && q.size() > 0) begin
			if (q[0][32]) chk(bus_dout_o, q[0][31:16]);
			else chk(rdata_o, q[0][15:0]);
			chk(maskable_interrupt_request_o, q[0][33]);
			chk(nmi_o, q[0][34]);
			chk(test_n_o, q[0][35]);
			void'(q.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		#1 sys_rst_i = 0;
		for (i = 0; i < 60; i++) begin
			req_i = 1;
			{req_word_i, req_write_i, slow, nmi_i, test_n_i} = $random(seed);
			maskable_interrupt_request_i = i[3];
			req_addr_i = $random(seed) & 20'h7ffff;
			req_wdata_i = $random(seed);
			q.push_back({test_n_i, nmi_i, maskable_interrupt_request_i, req_write_i,
				req_addr_i[0] ? (req_word_i ? {8'h00, req_wdata_i[15:8]}
				: {req_wdata_i[7:0], 8'h00})
				: (req_word_i ? req_wdata_i : {8'h00, req_wdata_i[7:0]}),
				req_word_i ? {f(req_addr_i + 20'h1), f(req_addr_i)}
				: {8'h0, f(req_addr_i)}});
			@(posedge clk_i);
			#1 req_i = 0;
			n = 0;
			while (!done_o && n < 200) begin
				@(posedge clk_i);
				#1 n++;
			end
			if (!done_o) err_total++;
		end
		$display("random access test done");
		report_and_stop;
	end
endmodule // test_byte_lane_steering
